// ### core/kasg_pkg.sv
// constants shared by the key-repeat, sleep and port configuration logic
package kasg_pkg;

  // clock and millisecond timebase
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned TICK_MS   = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;

  // register offsets
  localparam logic [7:0] ADDR_REPEAT  = 8'h05;
  localparam logic [7:0] ADDR_SLEEP   = 8'h06;
  localparam logic [7:0] ADDR_GLOBAL  = 8'h40;
  localparam logic [7:0] ADDR_TOFLAG  = 8'h48;
  localparam logic [7:0] ADDR_BANK_LO = 8'h41;
  localparam logic [7:0] ADDR_BANK_HI = 8'h5f;

  // reset values
  localparam logic [7:0] RST_REPEAT = 8'h00;
  localparam logic [3:0] RST_SLEEP  = 4'h7;
  localparam logic [7:0] RST_GLOBAL = 8'h00;

  // key_repeat_config fields
  localparam int unsigned RPT_EN_BIT    = 7;
  localparam int unsigned RPT_RATE_LSB  = 4;
  localparam int unsigned RPT_DELAY_LSB = 0;
  localparam logic [7:0]  DELAY_UNIT    = 8'h08;
  localparam logic [7:0]  RATE_UNIT     = 8'h04;

  // sleep_timeout_config field and timeouts in ms
  localparam int unsigned SLEEP_LSB        = 0;
  localparam logic [13:0] SLEEP_MAX_MS     = 14'h2000;
  localparam logic [3:0]  SLEEP_LAST_SHIFT = 4'h5;

  // port_global_config fields
  localparam int unsigned GLB_ROT_BIT   = 7;
  localparam int unsigned GLB_TOINT_BIT = 5;
  localparam int unsigned GLB_EN_BIT    = 4;
  localparam int unsigned GLB_RST_BIT   = 3;
  localparam int unsigned GLB_FADE_LSB  = 0;

  // fade timing
  localparam logic [8:0] FADE_BASE_MS   = 9'h100;
  localparam logic [4:0] FADE_STEPS     = 5'h10;
  localparam int unsigned FADE_SHIFT    = 4;
  localparam logic [2:0] FADE_OFF       = 3'h0;
  localparam logic [2:0] FADE_LAST_CODE = 3'h5;

  // autorepeat state machine
  typedef enum logic [2:0] {
    RPT_IDLE   = 3'b001,
    RPT_DELAY  = 3'b010,
    RPT_REPEAT = 3'b100
  } kasg_rpt_state_e;

endpackage

// ### core/kasg_fade.sv
// fade ramp of the common pwm intensity in sixteen equal steps
`timescale 1ns/1ps
module kasg_fade (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // control
  input  wire logic       ms_tick,
  input  wire logic       run,
  input  wire logic [2:0] fade_code,
  input  wire logic       fade_up,
  input  wire logic [7:0] common_pwm,
  // result
  output logic      [7:0] fade_pwm
);

  logic [4:0] lvl;
  logic [4:0] next_lvl;
  logic [8:0] ms_cnt;
  logic [8:0] next_ms_cnt;
  logic [7:0] next_fade_pwm;
  logic [4:0] target;
  logic [8:0] step_ms;
  logic [12:0] prod;

  // one step lasts a sixteenth of the ramp time
  always_comb begin
    target  = fade_up ? kasg_pkg::FADE_STEPS : 5'h00;
    step_ms = 9'((kasg_pkg::FADE_BASE_MS >> kasg_pkg::FADE_SHIFT)
              << (fade_code - 3'h1));
    next_lvl    = lvl;
    next_ms_cnt = ms_cnt;
    if (!run) begin
      // shut down: hold the level where it stands
      next_lvl = lvl;
    end else if (fade_code == kasg_pkg::FADE_OFF ||
                 fade_code > kasg_pkg::FADE_LAST_CODE) begin
      next_lvl    = target; // RQ10
      next_ms_cnt = 9'h000;
    end else if (lvl == target) begin
      next_ms_cnt = 9'h000;
    end else if (ms_tick) begin
      if (ms_cnt + 9'h001 >= step_ms) begin
        next_ms_cnt = 9'h000;
        next_lvl    = fade_up ? lvl + 5'h01 : lvl - 5'h01; // RQ10 RQ11
      end else begin
        next_ms_cnt = ms_cnt + 9'h001;
      end
    end
    prod          = 13'(common_pwm) * 13'(next_lvl);
    next_fade_pwm = 8'(prod >> kasg_pkg::FADE_SHIFT);
  end

  // ramp registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl      <= 5'h00;
      ms_cnt   <= 9'h000;
      fade_pwm <= 8'h00;
    end else begin
      lvl      <= next_lvl;
      ms_cnt   <= next_ms_cnt;
      fade_pwm <= next_fade_pwm;
    end
  end

endmodule

// ### core/kasg_ctrl.sv
// key autorepeat, autosleep and global port configuration registers
//
// Operation
// RQ1: no repeat when enable bit clear; first repeat after (n+1)*8 ticks
// RQ2: later repeats every (m+1)*4 debounce ticks from the rate field
// RQ3: sleep code 0 never sleeps; 1..7 give 8192 down to 256 ms idle
// RQ4: rotary bit selects gpio use or rotary decoding of pins six/seven
// RQ5: bus timeout drives interrupt low when enabled; read of 0x48 releases
// RQ6: port disable stops pwm, current, inputs; bank 0x41-0x5f locked
// RQ7: port disable while key section sleeps means full shutdown
// RQ8: port enable keeps pwm, current and ports running even when asleep
// RQ9: reset bit returns 0x40-0x5f to power-on values and reads back zero
// RQ10: fade code zero means no fade; codes 1..5 ramp in sixteen steps
// RQ11: fade codes 1..5 ramp over 256..4096 ms; 6 and 7 act as no fade
// RQ12: held key queues a repeat press after the delay, then every period
`timescale 1ns/1ps
module kasg_ctrl #(
  parameter int unsigned MS_CYCLES = kasg_pkg::MS_CYCLES,
  parameter int unsigned KEY_W     = 6
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // register port from the serial slave
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  // key scanner
  input  wire logic             debounce_tick,
  input  wire logic             key_press,
  input  wire logic             key_held,
  input  wire logic [KEY_W-1:0] key_code,
  output logic                  repeat_event,
  output logic      [KEY_W-1:0] repeat_key,
  output logic                  key_sleep,
  // serial bus timeout
  input  wire logic             bus_timeout,
  output logic                  port_interrupt_n,
  // rotary pins
  input  wire logic             gpio_pin_six_in,
  input  wire logic             gpio_pin_seven_in,
  output logic      [1:0]       gpi_value,
  output logic                  rotary_step,
  output logic                  rotary_dir,
  // port section control
  output logic                  gpio_run,
  output logic                  full_shutdown,
  output logic                  bank_wr_allow,
  output logic                  gpio_soft_reset,
  // fade
  input  wire logic             fade_up,
  input  wire logic [7:0]       common_pwm,
  output logic      [7:0]       fade_pwm
);

  localparam int unsigned DIV_W = $clog2(MS_CYCLES);

  // repeat period in debounce ticks from a field and its unit
  function automatic logic [7:0] rpt_cycles(input logic [3:0] f,
                                            input logic [7:0] unit);
    rpt_cycles = 8'((8'(f) + 8'h01) * unit);
  endfunction

  // autosleep limit in ms, zero meaning never
  function automatic logic [13:0] sleep_limit(input logic [3:0] code);
    logic [3:0] sh;
    sh = code - 4'h1;
    if (sh > kasg_pkg::SLEEP_LAST_SHIFT) begin
      sh = kasg_pkg::SLEEP_LAST_SHIFT;
    end
    sleep_limit = (code == 4'h0) ? 14'h0000 : kasg_pkg::SLEEP_MAX_MS >> sh;
  endfunction

  // register state
  logic [7:0] rpt_cfg;
  logic [7:0] next_rpt_cfg;
  logic [3:0] sleep_cfg;
  logic [3:0] next_sleep_cfg;
  logic       glb_rot;
  logic       next_glb_rot;
  logic       glb_toint;
  logic       next_glb_toint;
  logic       glb_en;
  logic       next_glb_en;
  logic [2:0] glb_fade;
  logic [2:0] next_glb_fade;
  logic       to_flag;
  logic       next_to_flag;
  logic       next_int_n;
  logic       next_soft_reset;
  logic [7:0] next_rdata;
  logic       wr_glb;

  // register writes, reads and timeout flag
  always_comb begin
    next_rpt_cfg    = rpt_cfg;
    next_sleep_cfg  = sleep_cfg;
    next_glb_rot    = glb_rot;
    next_glb_toint  = glb_toint;
    next_glb_en     = glb_en;
    next_glb_fade   = glb_fade;
    next_soft_reset = 1'b0;
    next_rdata      = reg_rdata;
    wr_glb          = reg_wr && reg_addr == kasg_pkg::ADDR_GLOBAL;
    if (reg_wr && reg_addr == kasg_pkg::ADDR_REPEAT) begin
      next_rpt_cfg = reg_wdata;
    end
    if (reg_wr && reg_addr == kasg_pkg::ADDR_SLEEP) begin
      next_sleep_cfg = reg_wdata[kasg_pkg::SLEEP_LSB +: 4];
    end
    if (wr_glb && reg_wdata[kasg_pkg::GLB_RST_BIT]) begin
      // the reset bit is never stored, so it always reads zero
      next_glb_rot    = kasg_pkg::RST_GLOBAL[kasg_pkg::GLB_ROT_BIT]; // RQ9
      next_glb_toint  = kasg_pkg::RST_GLOBAL[kasg_pkg::GLB_TOINT_BIT];
      next_glb_en     = kasg_pkg::RST_GLOBAL[kasg_pkg::GLB_EN_BIT];
      next_glb_fade   = kasg_pkg::RST_GLOBAL[kasg_pkg::GLB_FADE_LSB +: 3];
      next_soft_reset = 1'b1; // RQ9
    end else if (wr_glb) begin
      next_glb_rot   = reg_wdata[kasg_pkg::GLB_ROT_BIT];
      next_glb_toint = reg_wdata[kasg_pkg::GLB_TOINT_BIT];
      next_glb_en    = reg_wdata[kasg_pkg::GLB_EN_BIT];
      next_glb_fade  = reg_wdata[kasg_pkg::GLB_FADE_LSB +: 3];
    end
    // a timeout in the clearing read's cycle is kept
    next_to_flag = to_flag;
    if (reg_rd && reg_addr == kasg_pkg::ADDR_TOFLAG) begin
      next_to_flag = 1'b0; // RQ5
    end
    if (bus_timeout) begin
      next_to_flag = 1'b1;
    end
    next_int_n = ~(next_to_flag & next_glb_toint); // RQ5
    if (reg_rd) begin
      case (reg_addr)
        kasg_pkg::ADDR_REPEAT: next_rdata = rpt_cfg;
        kasg_pkg::ADDR_SLEEP:  next_rdata = {4'h0, sleep_cfg};
        kasg_pkg::ADDR_GLOBAL: begin
          next_rdata = 8'h00;
          next_rdata[kasg_pkg::GLB_ROT_BIT]        = glb_rot;
          next_rdata[kasg_pkg::GLB_TOINT_BIT]      = glb_toint;
          next_rdata[kasg_pkg::GLB_EN_BIT]         = glb_en;
          next_rdata[kasg_pkg::GLB_FADE_LSB +: 3]  = glb_fade;
        end
        kasg_pkg::ADDR_TOFLAG: next_rdata = {7'h00, to_flag};
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rpt_cfg          <= kasg_pkg::RST_REPEAT;
      sleep_cfg        <= kasg_pkg::RST_SLEEP;
      glb_rot          <= 1'b0;
      glb_toint        <= 1'b0;
      glb_en           <= 1'b0;
      glb_fade         <= kasg_pkg::FADE_OFF;
      to_flag          <= 1'b0;
      port_interrupt_n <= 1'b1;
      gpio_soft_reset  <= 1'b0;
      reg_rdata        <= 8'h00;
    end else begin
      rpt_cfg          <= next_rpt_cfg;
      sleep_cfg        <= next_sleep_cfg;
      glb_rot          <= next_glb_rot;
      glb_toint        <= next_glb_toint;
      glb_en           <= next_glb_en;
      glb_fade         <= next_glb_fade;
      to_flag          <= next_to_flag;
      port_interrupt_n <= next_int_n;
      gpio_soft_reset  <= next_soft_reset;
      reg_rdata        <= next_rdata;
    end
  end

  // port section power states follow the enable bit directly
  assign gpio_run      = glb_en;              // RQ8
  assign bank_wr_allow = glb_en;              // RQ6
  assign full_shutdown = ~glb_en & key_sleep; // RQ7

  // millisecond enable pulse
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             ms_tick;
  logic             next_ms_tick;

  always_comb begin
    next_ms_tick = 1'b0;
    next_div_cnt = div_cnt + 1'b1;
    if (div_cnt == DIV_W'(MS_CYCLES - 1)) begin
      next_div_cnt = '0;
      next_ms_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  // autorepeat timing counted in debounce ticks
  kasg_pkg::kasg_rpt_state_e rpt_st;
  kasg_pkg::kasg_rpt_state_e next_rpt_st;
  logic [7:0]       rpt_cnt;
  logic [7:0]       next_rpt_cnt;
  logic [KEY_W-1:0] next_repeat_key;
  logic             next_repeat_event;
  logic             rpt_on;

  always_comb begin
    rpt_on            = rpt_cfg[kasg_pkg::RPT_EN_BIT];
    next_rpt_st       = rpt_st;
    next_rpt_cnt      = rpt_cnt;
    next_repeat_key   = repeat_key;
    next_repeat_event = 1'b0;
    case (rpt_st)
      kasg_pkg::RPT_IDLE: begin
        if (key_press && rpt_on) begin
          next_rpt_st     = kasg_pkg::RPT_DELAY;
          next_repeat_key = key_code;
          next_rpt_cnt    = rpt_cycles(rpt_cfg[kasg_pkg::RPT_DELAY_LSB +: 4],
                                       kasg_pkg::DELAY_UNIT); // RQ1
        end
      end
      kasg_pkg::RPT_DELAY, kasg_pkg::RPT_REPEAT: begin
        if (!rpt_on || !key_held) begin
          next_rpt_st = kasg_pkg::RPT_IDLE; // RQ1 RQ12
        end else if (debounce_tick && rpt_cnt == 8'h01) begin
          next_repeat_event = 1'b1; // RQ12
          next_rpt_st       = kasg_pkg::RPT_REPEAT;
          next_rpt_cnt      = rpt_cycles(
              {1'b0, rpt_cfg[kasg_pkg::RPT_RATE_LSB +: 3]},
              kasg_pkg::RATE_UNIT); // RQ2
        end else if (debounce_tick) begin
          next_rpt_cnt = rpt_cnt - 8'h01;
        end
      end
      default: next_rpt_st = kasg_pkg::RPT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rpt_st       <= kasg_pkg::RPT_IDLE;
      rpt_cnt      <= 8'h00;
      repeat_key   <= '0;
      repeat_event <= 1'b0;
    end else begin
      rpt_st       <= next_rpt_st;
      rpt_cnt      <= next_rpt_cnt;
      repeat_key   <= next_repeat_key;
      repeat_event <= next_repeat_event;
    end
  end

  // autosleep: any key activity restarts the idle count and wakes
  logic [13:0] idle_ms;
  logic [13:0] next_idle_ms;
  logic        next_key_sleep;
  logic [13:0] limit_ms;

  always_comb begin
    limit_ms       = sleep_limit(sleep_cfg); // RQ3
    next_idle_ms   = idle_ms;
    next_key_sleep = key_sleep;
    if (key_press || key_held || limit_ms == 14'h0000) begin
      next_idle_ms   = 14'h0000;
      next_key_sleep = 1'b0;
    end else if (ms_tick && !key_sleep) begin
      if (idle_ms + 14'h0001 >= limit_ms) begin
        next_key_sleep = 1'b1; // RQ3
      end else begin
        next_idle_ms = idle_ms + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_ms   <= 14'h0000;
      key_sleep <= 1'b0;
    end else begin
      idle_ms   <= next_idle_ms;
      key_sleep <= next_key_sleep;
    end
  end

  // pins six/seven: two-stage sync, then gpio or gray-code decode
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] rot_prev;
  logic [1:0] next_gpi;
  logic       next_rot_step;
  logic       next_rot_dir;

  always_comb begin
    next_gpi      = 2'h0;
    next_rot_step = 1'b0;
    next_rot_dir  = rotary_dir;
    if (glb_en && !glb_rot) begin
      next_gpi = pin_sync; // RQ4 RQ6
    end
    if (glb_en && glb_rot && pin_sync != rot_prev) begin
      next_rot_step = 1'b1; // RQ4
      next_rot_dir  = rot_prev[0] ^ pin_sync[1];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta    <= 2'h3;
      pin_sync    <= 2'h3;
      rot_prev    <= 2'h3;
      gpi_value   <= 2'h0;
      rotary_step <= 1'b0;
      rotary_dir  <= 1'b0;
    end else begin
      pin_meta    <= {gpio_pin_seven_in, gpio_pin_six_in};
      pin_sync    <= pin_meta;
      rot_prev    <= pin_sync;
      gpi_value   <= next_gpi;
      rotary_step <= next_rot_step;
      rotary_dir  <= next_rot_dir;
    end
  end

  // fade ramp runs only while the port section is enabled
  kasg_fade u_fade (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .ms_tick    (ms_tick),
    .run        (glb_en),
    .fade_code  (glb_fade),
    .fade_up    (fade_up),
    .common_pwm (common_pwm),
    .fade_pwm   (fade_pwm)
  );

endmodule

// ### verification/kasg_ctrl_props.sv
// port-level assertions for the configuration block
`timescale 1ns/1ps
module kasg_ctrl_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // register port and key scanner
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       debounce_tick,
  input wire logic       key_held,
  input wire logic       repeat_event,
  input wire logic       key_sleep,
  // timeout and port control
  input wire logic       bus_timeout,
  input wire logic       port_interrupt_n,
  input wire logic [1:0] gpi_value,
  input wire logic       gpio_run,
  input wire logic       full_shutdown,
  input wire logic       bank_wr_allow,
  input wire logic       gpio_soft_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // decoded requests seen on the register port
  wire glb_wr  = reg_wr && reg_addr == kasg_pkg::ADDR_GLOBAL;
  wire rst_wr  = glb_wr && reg_wdata[kasg_pkg::GLB_RST_BIT];
  wire en_bit  = reg_wdata[kasg_pkg::GLB_EN_BIT];
  wire flag_rd = reg_rd && reg_addr == kasg_pkg::ADDR_TOFLAG;
  sequence s_rst_wr;
    rst_wr;
  endsequence
  sequence s_en_wr;
    glb_wr && !rst_wr;
  endsequence
  AST_RPT_TICK: assert property (repeat_event |-> $past(debounce_tick))
    else $error("repeat without debounce tick");
  AST_RPT_HELD: assert property (repeat_event |-> $past(key_held))
    else $error("repeat with no key held");
  AST_INT_SET: assert property ($fell(port_interrupt_n) |->
    $past(bus_timeout) || $past(glb_wr) || $past(glb_wr, 2))
    else $error("interrupt fell without cause");
  AST_INT_REL: assert property ($rose(port_interrupt_n) |->
    $past(flag_rd) || $past(glb_wr) || $past(glb_wr, 2))
    else $error("interrupt released without flag read");
  AST_SHDN: assert property (full_shutdown == (!gpio_run && key_sleep))
    else $error("full shutdown mismatch");
  AST_BANK: assert property ((bank_wr_allow == gpio_run) and
    (s_en_wr |=> bank_wr_allow == $past(en_bit)))
    else $error("bank lock does not follow enable");
  AST_SOFT: assert property (s_rst_wr |=> gpio_soft_reset && !gpio_run)
    else $error("soft reset not applied");
  AST_SOFT_SRC: assert property (gpio_soft_reset |-> $past(rst_wr))
    else $error("soft reset pulse without write");
  AST_EN: assert property (s_en_wr |=> gpio_run == $past(en_bit))
    else $error("enable bit not taken");
  AST_GPI_OFF: assert property (
    !gpio_run && !$past(gpio_run) |-> gpi_value == 2'h0)
    else $error("inputs active while disabled");
endmodule
bind kasg_ctrl kasg_ctrl_props u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .debounce_tick(debounce_tick),
  .key_held(key_held), .repeat_event(repeat_event), .key_sleep(key_sleep),
  .bus_timeout(bus_timeout), .port_interrupt_n(port_interrupt_n),
  .gpi_value(gpi_value), .gpio_run(gpio_run), .full_shutdown(full_shutdown),
  .bank_wr_allow(bank_wr_allow), .gpio_soft_reset(gpio_soft_reset));

// ### verification/kasg_host.sv
// host model issuing byte writes and reads on the register port
`timescale 1ns/1ps
module kasg_host (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle from time zero; released fields show the inverse value
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe; callers never send fade codes 110/111
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // data is registered at the strobe edge and held afterwards
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ### verification/kasg_ctrl_tb.sv
// self-checking bench for the configuration block
`timescale 1ns/1ps
module kasg_ctrl_tb;
  localparam int unsigned MSC = 4;
  logic       clk_sys, arst_n, reg_wr, reg_rd, debounce_tick, key_press;
  logic       key_held, repeat_event, key_sleep, bus_timeout, irq_n;
  logic       pin6, pin7, gpio_run, full_shutdown, bank_wr_allow, fade_up;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, common_pwm, fade_pwm, d;
  logic [5:0] key_code, repeat_key;
  logic [1:0] gpi_value;
  logic       rot_step, rot_dir, soft_rst;
  int         fails, compares, cycles;
  // short ms timebase keeps sleep and fade runs brief
  kasg_ctrl #(.MS_CYCLES(MSC), .KEY_W(6)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .debounce_tick(debounce_tick), .key_press(key_press),
    .key_held(key_held), .key_code(key_code), .repeat_event(repeat_event),
    .repeat_key(repeat_key), .key_sleep(key_sleep),
    .bus_timeout(bus_timeout), .port_interrupt_n(irq_n),
    .gpio_pin_six_in(pin6), .gpio_pin_seven_in(pin7),
    .gpi_value(gpi_value), .rotary_step(rot_step), .rotary_dir(rot_dir),
    .gpio_run(gpio_run), .full_shutdown(full_shutdown),
    .bank_wr_allow(bank_wr_allow), .gpio_soft_reset(soft_rst),
    .fade_up(fade_up), .common_pwm(common_pwm), .fade_pwm(fade_pwm));
  kasg_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic complete_run;
    $display("counts compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hang counts as a mismatch; the whole run needs about 2600 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      complete_run;
    end
  end
  // one debounce tick; a repeat shows in the cycle after the tick edge
  task automatic tick(output logic ev);
    @(posedge clk_sys);
    debounce_tick <= 1'h1;
    @(posedge clk_sys);
    debounce_tick <= 1'h0;
    #1;
    ev = repeat_event;
  endtask
  task automatic press(input logic held);
    @(posedge clk_sys);
    key_press <= 1'h1;
    key_held <= 1'h1;
    key_code <= 6'h2a;
    @(posedge clk_sys);
    key_press <= 1'h0;
    key_held <= held;
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h05, 8'h06, 8'h40, 8'h10, 8'h05};
    logic [7:0] r [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'hff};
    logic [7:0] w [5] = '{8'hff, 8'hff, 8'he5, 8'hff, 8'h00};
    logic [7:0] e [5] = '{8'hff, 8'h0f, 8'ha5, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      host.rd(a[i], d);
      chk("reset value", r[i], d);
      host.wr(a[i], w[i]);
      host.rd(a[i], d);
      chk("read back", e[i], d);
    end
    $display("test regs done");
  endtask
  task automatic t_repeat;
    logic ev;
    int   last, n;
    host.wr(kasg_pkg::ADDR_REPEAT, 8'ha1); // delay 16 ticks, rate 12
    press(1'h1);
    last = 0;
    n = 0;
    for (int i = 1; i <= 60; i++) begin
      if (i == 41) key_held <= 1'h0;
      tick(ev);
      if (ev !== 1'h0) begin
        chk("repeat gap", (n == 0) ? 8'h10 : 8'h0c, 8'(i - last));
        chk("repeat key", 8'h2a, {2'h0, repeat_key});
        last = i;
        n++;
      end
    end
    chk("repeat count", 8'h03, 8'(n));
    host.wr(kasg_pkg::ADDR_REPEAT, 8'h0f); // longest delay, disabled
    press(1'h1);
    n = 0;
    for (int i = 0; i < 130; i++) begin
      tick(ev);
      if (ev !== 1'h0) n++;
    end
    key_held <= 1'h0;
    chk("repeat off", 8'h00, 8'(n));
    $display("test repeat done");
  endtask
  task automatic t_timeout;
    for (int k = 0; k < 2; k++) begin
      host.wr(kasg_pkg::ADDR_GLOBAL, (k == 0) ? 8'h30 : 8'h90);
      @(posedge clk_sys);
      bus_timeout <= 1'h1;
      @(posedge clk_sys);
      bus_timeout <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("irq", 8'(k), 8'(irq_n));
      chk("gpi", (k == 0) ? 8'h02 : 8'h00, 8'(gpi_value));
      if (k == 1) begin
        // pin six rises: prev six 0, new seven 1, so one step with dir 1
        @(posedge clk_sys);
        pin6 <= 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("rotary", 8'h03, {6'h0, rot_step, rot_dir});
      end
      host.rd(kasg_pkg::ADDR_TOFLAG, d);
      chk("timeout flag", 8'h01, d);
      repeat (2) @(posedge clk_sys);
      chk("irq released", 8'h01, 8'(irq_n));
    end
    $display("test timeout done");
  endtask
  task automatic t_sleep;
    host.wr(kasg_pkg::ADDR_GLOBAL, 8'h00);
    host.wr(kasg_pkg::ADDR_SLEEP, 8'h07); // 256 ms of idle
    press(1'h0);
    repeat (256 * MSC - 40) @(posedge clk_sys);
    #1;
    chk("awake", 8'h00, 8'(key_sleep));
    repeat (80) @(posedge clk_sys);
    chk("asleep", 8'h01, 8'(key_sleep));
    chk("full shutdown", 8'h01, 8'(full_shutdown));
    chk("bank lock", 8'h00, 8'(bank_wr_allow));
    host.wr(kasg_pkg::ADDR_GLOBAL, 8'h10);
    #1;
    chk("run while asleep", 8'h03, {6'h0, gpio_run, key_sleep});
    chk("no shutdown", 8'h00, 8'(full_shutdown));
    $display("test sleep done");
  endtask
  task automatic t_fade;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("no fade", 8'h80, fade_pwm);
    host.wr(kasg_pkg::ADDR_GLOBAL, 8'h11); // 16 steps over 256 ms
    // turn down only once the code stands, else code 0 jumps straight to 0
    fade_up <= 1'h0;
    repeat (128 * MSC) @(posedge clk_sys);
    chk("fade midway", 8'h01, 8'(fade_pwm > 8'h20 && fade_pwm < 8'h60));
    repeat (128 * MSC + 40) @(posedge clk_sys);
    chk("fade end", 8'h00, fade_pwm);
    host.wr(kasg_pkg::ADDR_GLOBAL, 8'h18);
    #1;
    chk("soft reset pulse", 8'h01, {7'h00, soft_rst});
    host.rd(kasg_pkg::ADDR_GLOBAL, d);
    chk("soft reset", 8'h00, d);
    $display("test fade done");
  endtask
  initial begin
    arst_n = 1'h0;
    debounce_tick = 1'h0;
    key_press = 1'h0;
    key_held = 1'h0;
    key_code = 6'h00;
    bus_timeout = 1'h0;
    pin6 = 1'h0;
    pin7 = 1'h1;
    fade_up = 1'h1;
    common_pwm = 8'h80;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_regs;
    t_repeat;
    t_timeout;
    t_sleep;
    t_fade;
    complete_run;
  end
endmodule
